//--- rtl/pcr_pkg.sv
// ****************************************************************
// Shared constants for the configuration and symbol error registers.
// ****************************************************************
package pcr_pkg;

	// ****************************************************************
	// Register addresses on the management interface.
	// ****************************************************************
	localparam logic [4:0] PCR_ADDR_CFG_ONE = 5'h12; // First configuration register.
	localparam logic [4:0] PCR_ADDR_CFG_TWO = 5'h13; // Second configuration register.
	localparam logic [4:0] PCR_ADDR_SYMERR = 5'h14; // Symbol error counter.

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int PCR_CABLE_LEN_BIT = 13; // Obsolete cable-length bit.
	localparam int PCR_SELF_PWD_BIT = 1; // Self power-down enable bit.
	localparam int PCR_ADDR_LSB = 11; // Management address field, bits 15:11.
	localparam int PCR_AVG_LSB = 9; // Averaging length field, bits 10:9.
	localparam int PCR_WARN_LSB = 6; // Warning threshold field, bits 8:6.
	localparam int PCR_FAIL_LSB = 3; // Fail threshold field, bits 5:3.
	localparam int PCR_JUMBO_BIT = 2; // Jumbo packet enable bit.
	localparam int PCR_SLEEP_LSB = 0; // Sleep request time-out field, bits 1:0.

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [2:0] PCR_ADDR_UPPER = 3'h1; // Fixed upper address bits.
	localparam logic [1:0] PCR_AVG_RST = 2'h1; // Averaging over 64 symbols.
	localparam logic [2:0] PCR_WARN_RST = 3'h1; // Class A warning threshold.
	localparam logic [2:0] PCR_FAIL_RST = 3'h0; // No fail threshold.
	localparam logic PCR_JUMBO_RST = 1'b1; // Packets up to 16 kB.
	localparam logic [1:0] PCR_SLEEP_RST = 2'h1; // 1 ms time-out.
	localparam logic [15:0] PCR_SYMERR_RST = 16'h0000; // Counter start value.
	localparam logic [15:0] PCR_SYMERR_MAX = 16'hffff; // Saturation value.

	// ****************************************************************
	// Management frame constants.
	// ****************************************************************
	localparam logic [5:0] PCR_PREAMBLE_LEN = 6'h20; // Ones needed before a start.
	localparam logic [1:0] PCR_OP_WRITE = 2'h1; // Write opcode.
	localparam logic [1:0] PCR_OP_READ = 2'h2; // Read opcode.

	// ****************************************************************
	// Timing, in the units given, and the clock rate.
	// ****************************************************************
	localparam int PCR_CLK_KHZ = 10000; // Reference clock rate in kHz.
	localparam int PCR_INDICATOR_STRETCH_TIME_US = 20; // Indicator stretch in us.
	localparam int PCR_INDICATOR_STRETCH_CYC =
		(PCR_INDICATOR_STRETCH_TIME_US * PCR_CLK_KHZ + 999) / 1000;
	localparam int PCR_SLEEP_TO0_US = 400; // Time-out code 0 in us.
	localparam int PCR_SLEEP_TO1_US = 1000; // Time-out code 1 in us.
	localparam int PCR_SLEEP_TO2_US = 4000; // Time-out code 2 in us.
	localparam int PCR_SLEEP_TO3_US = 16000; // Time-out code 3 in us.

	// ****************************************************************
	// Enumerations.
	// ****************************************************************
	typedef enum logic [1:0] {
		PCR_PWR_NORMAL = 2'h0,
		PCR_PWR_SLEEP = 2'h1,
		PCR_PWR_SLEEP_REQ = 2'h2,
		PCR_PWR_STANDBY = 2'h3
	} pcr_pwr_mode_t;

	typedef enum logic [2:0] {
		PCR_ST_PRE = 3'h0,
		PCR_ST_HDR = 3'h1,
		PCR_ST_TA = 3'h2,
		PCR_ST_RD = 3'h3,
		PCR_ST_WR = 3'h4
	} pcr_state_t;

endpackage

//--- rtl/pcr_regs.sv
// Summary of operation
// - Config one bit 0 reserved, reads zero.
// - Strap-dependent fields load from strap pins.
// - Obsolete cable-length bit resets to zero.
// - Active indicator output is stretched fixed time.
// - Indicator disabled enables wake in low modes.
// - Config two 15:11 reads address, upper 001.
// - Address matches management frames.
// - Bits 10:9 select averaging, reset 01.
// - Bits 8:6 warning threshold, reset 001.
// - Bits 5:3 fail threshold, reset 000.
// - Bit 2 jumbo packets, reset one.
// - Counter counts invalid symbols, idle included.
// - At most one count per packet.
// - Counter saturates at FFFFh.
// - Read returns count then clears it.
// - Link control off keeps the count.
// - Manager clears link control before wake request.
`timescale 1ns/100ps
module pcr_regs
	import pcr_pkg::*;
#(
	parameter int SLEEP_TO0_CYC = PCR_SLEEP_TO0_US * (PCR_CLK_KHZ / 1000),
	parameter int SLEEP_TO1_CYC = PCR_SLEEP_TO1_US * (PCR_CLK_KHZ / 1000),
	parameter int SLEEP_TO2_CYC = PCR_SLEEP_TO2_US * (PCR_CLK_KHZ / 1000),
	parameter int SLEEP_TO3_CYC = PCR_SLEEP_TO3_US * (PCR_CLK_KHZ / 1000)
) (
	// Clock, reset and enable.
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Management interface, sampled on the reference clock.
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	// Straps and device status.
	input wire logic [1:0] addr_strap_i,
	input wire logic [1:0] power_mode_i,
	input wire logic link_ctrl_en_i,
	input wire logic sym_err_i,
	input wire logic rx_in_packet_i,
	input wire logic sleep_req_active_i,
	input wire logic indicator_raw_i,
	input wire logic wake_pin_i,
	// Configuration outputs.
	output logic self_power_down_en_o,
	output logic [4:0] phy_mgmt_addr_o,
	output logic [1:0] quality_avg_len_o,
	output logic [2:0] quality_warn_thresh_o,
	output logic [2:0] quality_fail_thresh_o,
	output logic jumbo_en_o,
	output logic [1:0] sleep_req_timeout_o,
	// Derived outputs.
	output logic sleep_req_expired_o,
	output logic indicator_o,
	output logic local_wake_en_o,
	output logic local_wake_o
);

	// ****************************************************************
	// Elaboration checks.
	// ****************************************************************
	generate
		if (SLEEP_TO0_CYC < 1 || SLEEP_TO1_CYC < 1 || SLEEP_TO2_CYC < 1 ||
			SLEEP_TO3_CYC < 1 || SLEEP_TO3_CYC > 262143 ||
			PCR_INDICATOR_STRETCH_CYC < 1 || PCR_INDICATOR_STRETCH_CYC > 4095) begin : g_bad
			$error("pcr_regs: time-out counts out of range");
		end
	endgenerate

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	pcr_state_t state; // Frame state.
	logic mdc_q; // Previous management clock sample.
	logic mdc_rise; // Management clock rising edge, gated by enable.
	logic [5:0] ones_cnt; // Preamble ones seen.
	logic [4:0] bit_cnt; // Bit count within a frame phase.
	logic [11:0] hdr_sh; // Header bits collected so far.
	logic [12:0] hdr; // Complete header including the last bit.
	logic hdr_ours; // Header addresses one of our registers.
	logic is_read; // Current frame is a read.
	logic [4:0] reg_sel; // Register addressed by the frame.
	logic [15:0] data_sh; // Read or write data shift register.
	logic [15:0] rd_word; // Read value of the addressed register.
	logic wr_commit; // Last write data bit seen this cycle.
	logic [15:0] wr_word; // Complete write data word.
	logic sym_clear; // Read of the counter clears it.
	logic cable_len; // Obsolete cable-length bit, no effect.
	logic strap_done; // Straps captured after reset.
	logic [15:0] sym_cnt; // Symbol error count.
	logic pkt_counted; // This packet already added one.
	logic sym_inc; // Count one this cycle.
	logic [15:0] next_sym_cnt; // Next symbol error count.
	logic [17:0] sleep_cnt; // Sleep request time counter.
	logic [17:0] sleep_lim; // Selected time-out in cycles.
	logic [11:0] stretch_cnt; // Indicator stretch remaining.
	logic low_power; // Device in Sleep, Sleep Request or Standby.
	logic indicator_out_en_q; // Indicator output enable, whose home is outside this bank.

	assign mdc_rise = ce_i & mdc_i & ~mdc_q;
	assign hdr = {hdr_sh, mdio_i};
	assign wr_word = {data_sh[14:0], mdio_i};
	assign wr_commit = mdc_rise && state == PCR_ST_WR && bit_cnt == 5'd15;

	// Only the three registers of this bank answer; others belong elsewhere.
	assign hdr_ours = hdr[12] && hdr[9:5] == phy_mgmt_addr_o &&
		(hdr[11:10] == PCR_OP_READ || hdr[11:10] == PCR_OP_WRITE) &&
		(hdr[4:0] == PCR_ADDR_CFG_ONE || hdr[4:0] == PCR_ADDR_CFG_TWO ||
		hdr[4:0] == PCR_ADDR_SYMERR);

	// The count is taken and cleared as the header of a read completes.
	assign sym_clear = mdc_rise && state == PCR_ST_HDR && bit_cnt == 5'd12 &&
		hdr_ours && hdr[11:10] == PCR_OP_READ && hdr[4:0] == PCR_ADDR_SYMERR;

	// ****************************************************************
	// Read data assembly.
	// ****************************************************************
	// Unused bits of the first register read zero in this bank.
	always_comb begin
		rd_word = 16'h0000;
		if (hdr[4:0] == PCR_ADDR_CFG_ONE) begin
			rd_word[PCR_CABLE_LEN_BIT] = cable_len;
			rd_word[PCR_SELF_PWD_BIT] = self_power_down_en_o;
			rd_word[0] = 1'b0;
		end else if (hdr[4:0] == PCR_ADDR_CFG_TWO) begin
			rd_word = {phy_mgmt_addr_o, quality_avg_len_o, quality_warn_thresh_o,
				quality_fail_thresh_o, jumbo_en_o, sleep_req_timeout_o};
		end else if (hdr[4:0] == PCR_ADDR_SYMERR) begin
			rd_word = sym_cnt;
		end
	end

	// ****************************************************************
	// Management frame engine.
	// ****************************************************************
	// Edge detect on the management clock; the input is already synchronous.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mdc_q <= 1'b0;
		end else if (ce_i) begin
			mdc_q <= mdc_i;
		end
	end

	// Data changes just after a rising edge, a full period before the manager samples it.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= PCR_ST_PRE;
			ones_cnt <= 6'h00;
			bit_cnt <= 5'h00;
			hdr_sh <= 12'h000;
			is_read <= 1'b0;
			reg_sel <= 5'h00;
			data_sh <= 16'h0000;
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
		end else if (mdc_rise) begin
			case (state)
				PCR_ST_PRE: begin
					// A zero after enough ones is the first start bit.
					if (mdio_i) begin
						if (ones_cnt != PCR_PREAMBLE_LEN) begin
							ones_cnt <= ones_cnt + 6'h01;
						end
					end else begin
						if (ones_cnt == PCR_PREAMBLE_LEN) begin
							state <= PCR_ST_HDR;
						end
						ones_cnt <= 6'h00;
						bit_cnt <= 5'h00;
					end
				end
				PCR_ST_HDR: begin
					hdr_sh <= hdr[11:0];
					bit_cnt <= bit_cnt + 5'h01;
					if (bit_cnt == 5'd12) begin
						bit_cnt <= 5'h00;
						is_read <= hdr[11:10] == PCR_OP_READ;
						reg_sel <= hdr[4:0];
						data_sh <= rd_word;
						state <= hdr_ours ? PCR_ST_TA : PCR_ST_PRE;
					end
				end
				PCR_ST_TA: begin
					// First turnaround bit: a reader starts driving zero.
					if (bit_cnt == 5'h00) begin
						bit_cnt <= 5'h01;
						mdio_oe_o <= is_read;
						mdio_o <= 1'b0;
					end else begin
						bit_cnt <= 5'h00;
						mdio_o <= is_read & data_sh[15];
						state <= is_read ? PCR_ST_RD : PCR_ST_WR;
					end
				end
				PCR_ST_RD: begin
					bit_cnt <= bit_cnt + 5'h01;
					data_sh <= {data_sh[14:0], 1'b0};
					mdio_o <= data_sh[14];
					if (bit_cnt == 5'd15) begin
						mdio_oe_o <= 1'b0;
						mdio_o <= 1'b0;
						state <= PCR_ST_PRE;
					end
				end
				PCR_ST_WR: begin
					bit_cnt <= bit_cnt + 5'h01;
					data_sh <= wr_word;
					if (bit_cnt == 5'd15) begin
						state <= PCR_ST_PRE;
					end
				end
				default: begin
					state <= PCR_ST_PRE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************
	// The reserved bit is never stored, so it reads zero whatever is written.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cable_len <= 1'b0;
			self_power_down_en_o <= 1'b0;
		end else if (ce_i && wr_commit && reg_sel == PCR_ADDR_CFG_ONE) begin
			cable_len <= wr_word[PCR_CABLE_LEN_BIT];
			self_power_down_en_o <= wr_word[PCR_SELF_PWD_BIT];
		end
	end

	// Writable fields of the second register.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			quality_avg_len_o <= PCR_AVG_RST;
			quality_warn_thresh_o <= PCR_WARN_RST;
			quality_fail_thresh_o <= PCR_FAIL_RST;
			jumbo_en_o <= PCR_JUMBO_RST;
			sleep_req_timeout_o <= PCR_SLEEP_RST;
		end else if (ce_i && wr_commit && reg_sel == PCR_ADDR_CFG_TWO) begin
			quality_avg_len_o <= wr_word[PCR_AVG_LSB +: 2];
			quality_warn_thresh_o <= wr_word[PCR_WARN_LSB +: 3];
			quality_fail_thresh_o <= wr_word[PCR_FAIL_LSB +: 3];
			jumbo_en_o <= wr_word[PCR_JUMBO_BIT];
			sleep_req_timeout_o <= wr_word[PCR_SLEEP_LSB +: 2];
		end
	end

	// Straps are caught on the first enabled edge; the async reset loads only a constant.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			strap_done <= 1'b0;
			phy_mgmt_addr_o <= 5'h00;
		end else if (ce_i && !strap_done) begin
			strap_done <= 1'b1;
			phy_mgmt_addr_o <= {PCR_ADDR_UPPER, addr_strap_i};
		end
	end

	// ****************************************************************
	// Symbol error counter.
	// ****************************************************************
	// Inside a packet only the first bad symbol counts; in idle each one does.
	assign sym_inc = sym_err_i && !(rx_in_packet_i && pkt_counted);

	// A new error in the clearing cycle survives as a count of one.
	always_comb begin
		next_sym_cnt = sym_cnt;
		if (sym_clear) begin
			next_sym_cnt = sym_inc ? 16'h0001 : PCR_SYMERR_RST;
		end else if (sym_inc && sym_cnt != PCR_SYMERR_MAX) begin
			next_sym_cnt = sym_cnt + 16'h0001;
		end
	end

	// Link control is not read here, so turning it off keeps the count.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sym_cnt <= PCR_SYMERR_RST;
		end else if (ce_i) begin
			sym_cnt <= next_sym_cnt;
		end
	end

	// Packet marker: set by a counted error, dropped outside packets.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pkt_counted <= 1'b0;
		end else if (ce_i) begin
			pkt_counted <= rx_in_packet_i && (pkt_counted || sym_err_i);
		end
	end

	// ****************************************************************
	// Sleep request time-out.
	// ****************************************************************
	always_comb begin
		case (sleep_req_timeout_o)
			2'h0: sleep_lim = 18'(SLEEP_TO0_CYC);
			2'h1: sleep_lim = 18'(SLEEP_TO1_CYC);
			2'h2: sleep_lim = 18'(SLEEP_TO2_CYC);
			default: sleep_lim = 18'(SLEEP_TO3_CYC);
		endcase
	end

	// Counts while a sleep request lasts; flags expiry until it ends.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sleep_cnt <= 18'h00000;
			sleep_req_expired_o <= 1'b0;
		end else if (ce_i) begin
			if (!sleep_req_active_i) begin
				sleep_cnt <= 18'h00000;
				sleep_req_expired_o <= 1'b0;
			end else if (sleep_cnt >= sleep_lim - 18'h00001) begin
				sleep_req_expired_o <= 1'b1;
			end else begin
				sleep_cnt <= sleep_cnt + 18'h00001;
			end
		end
	end

	// ****************************************************************
	// Indicator output and local wake input.
	// ****************************************************************
	// The stretch reloads while the source is high and runs down after, so short events show.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stretch_cnt <= 12'h000;
			indicator_o <= 1'b0;
		end else if (ce_i) begin
			if (indicator_raw_i) begin
				stretch_cnt <= 12'(PCR_INDICATOR_STRETCH_CYC);
			end else if (stretch_cnt != 12'h000) begin
				stretch_cnt <= stretch_cnt - 12'h001;
			end
			indicator_o <= indicator_out_en_q && (indicator_raw_i || stretch_cnt != 12'h000);
		end
	end

	// Local enable copy, cleared at reset so the shared pin starts as wake input.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			indicator_out_en_q <= 1'b0;
		end else if (ce_i && wr_commit && reg_sel == PCR_ADDR_CFG_ONE) begin
			indicator_out_en_q <= wr_word[3];
		end
	end
	assign low_power = power_mode_i == PCR_PWR_SLEEP || power_mode_i == PCR_PWR_SLEEP_REQ ||
		power_mode_i == PCR_PWR_STANDBY;

	// Wake is accepted only while the pin is not driving the indicator.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			local_wake_en_o <= 1'b0;
			local_wake_o <= 1'b0;
		end else if (ce_i) begin
			local_wake_en_o <= !indicator_out_en_q && low_power;
			local_wake_o <= !indicator_out_en_q && low_power && wake_pin_i;
		end
	end

endmodule

//--- test/pcr_regs_chk.sv
`timescale 1ns/100ps
module pcr_regs_chk
	import pcr_pkg::*;
#(
	parameter int SLEEP_TO0_CYC = 4,
	parameter int SLEEP_TO1_CYC = 8,
	parameter int SLEEP_TO2_CYC = 12,
	parameter int SLEEP_TO3_CYC = 16
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Inputs that outputs depend on.
	input wire logic [1:0] addr_strap_i,
	input wire logic [1:0] power_mode_i,
	input wire logic sleep_req_active_i,
	input wire logic indicator_raw_i,
	input wire logic wake_pin_i,
	// Watched outputs.
	input wire logic mdio_o,
	input wire logic mdio_oe_o,
	input wire logic [4:0] phy_mgmt_addr_o,
	input wire logic [1:0] quality_avg_len_o,
	input wire logic [2:0] quality_warn_thresh_o,
	input wire logic [2:0] quality_fail_thresh_o,
	input wire logic jumbo_en_o,
	input wire logic [1:0] sleep_req_timeout_o,
	input wire logic sleep_req_expired_o,
	input wire logic indicator_o,
	input wire logic local_wake_en_o,
	input wire logic local_wake_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	// Cycles since the indicator source was last high; capped so it never wraps.
	int quiet_cnt;
	// Cycles the sleep request has stood high without a break.
	int req_cnt;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i || indicator_raw_i) begin
			quiet_cnt <= 0;
		end else if (quiet_cnt < 1000) begin
			quiet_cnt <= quiet_cnt + 1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i || !sleep_req_active_i) begin
			req_cnt <= 0;
		end else if (req_cnt < 100000) begin
			req_cnt <= req_cnt + 1;
		end
	end
	property p_rst_cfg;
		$rose(nrst_i) |-> {quality_avg_len_o, quality_warn_thresh_o, quality_fail_thresh_o,
			jumbo_en_o, sleep_req_timeout_o} == 11'h245;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("config reset value wrong");
	property p_addr;
		phy_mgmt_addr_o != 5'h0 |-> phy_mgmt_addr_o == {3'b001, addr_strap_i};
	endproperty
	a_addr: assert property (p_addr) else $error("address not upper 001 plus strap");
	property p_addr_hold;
		$past(phy_mgmt_addr_o) != 5'h0 |-> $stable(phy_mgmt_addr_o);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address changed");
	property p_wake_en;
		local_wake_en_o |-> $past(power_mode_i) != 2'h0;
	endproperty
	a_wake_en: assert property (p_wake_en) else $error("wake enabled in normal mode");
	property p_wake;
		local_wake_o == (local_wake_en_o && $past(wake_pin_i));
	endproperty
	a_wake: assert property (p_wake) else $error("wake output mismatch");
	property p_ind_hold;
		indicator_o && indicator_raw_i ##1 !indicator_raw_i |-> indicator_o [*8];
	endproperty
	a_ind_hold: assert property (p_ind_hold) else $error("indicator not stretched");
	property p_ind_bound;
		indicator_o |-> quiet_cnt <= PCR_INDICATOR_STRETCH_CYC + 2;
	endproperty
	a_ind_bound: assert property (p_ind_bound) else $error("indicator stretched too long");
	property p_oe_start;
		$rose(mdio_oe_o) |-> !mdio_o ##1 mdio_oe_o [*8];
	endproperty
	a_oe_start: assert property (p_oe_start) else $error("read turnaround wrong");
	property p_sleep_drop;
		!sleep_req_active_i |=> !sleep_req_expired_o;
	endproperty
	a_sleep_drop: assert property (p_sleep_drop) else $error("expired without request");
	property p_sleep_min;
		$rose(sleep_req_expired_o) |-> req_cnt >= SLEEP_TO0_CYC - 1;
	endproperty
	a_sleep_min: assert property (p_sleep_min) else $error("time-out too early");
	property p_sleep_max;
		sleep_req_active_i && req_cnt == SLEEP_TO3_CYC + 3 |-> sleep_req_expired_o;
	endproperty
	a_sleep_max: assert property (p_sleep_max) else $error("time-out too late");
	c_read: cover property ($rose(mdio_oe_o));
	c_expired: cover property ($rose(sleep_req_expired_o));
	c_stretch: cover property (indicator_o && !indicator_raw_i);
endmodule

//--- test/pcr_mgr.sv
`timescale 1ns/100ps
module pcr_mgr
	import pcr_pkg::*;
(
	// Clock and the resolved data line.
	input wire logic ref_clk_i,
	input wire logic mdio_i,
	// Manager drive; mdc stays low between frames.
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o
);
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end
	// One mdc period of four reference clocks, two low and two high, the least allowed.
	// Data is sampled just before the rise, so it shows the answer to the previous rise.
	task automatic bit_cyc(input logic b, input logic drv, output logic s);
		@(posedge ref_clk_i);
		mdc_o <= 1'b0;
		mdio_o <= b;
		mdio_oe_o <= drv;
		repeat (2) @(posedge ref_clk_i);
		s = mdio_i;
		mdc_o <= 1'b1;
		@(posedge ref_clk_i);
	endtask
	// A whole frame; on reads the line is released from the turnaround on.
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		logic s;
		if (rg == PCR_ADDR_CFG_ONE) begin
			wd[0] = 1'b0;
		end
		f = {32'hffffffff, 2'b01, op, phy, rg, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			bit_cyc(f[i], op != PCR_OP_READ || i > 17, s);
			if (i < 16) begin
				rd[i] = s;
			end
		end
		@(posedge ref_clk_i);
		mdc_o <= 1'b0;
		mdio_oe_o <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
	endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/100ps
bind pcr_regs pcr_regs_chk #(.SLEEP_TO0_CYC(SLEEP_TO0_CYC), .SLEEP_TO1_CYC(SLEEP_TO1_CYC),
	.SLEEP_TO2_CYC(SLEEP_TO2_CYC), .SLEEP_TO3_CYC(SLEEP_TO3_CYC)) pcr_regs_chk_inst (.*);
module testbench
	import pcr_pkg::*;
	;
	logic ref_clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1;
	logic mdc, mdio_w, mdio_o, mdio_oe_o, mgr_d, mgr_oe;
	logic [1:0] strap, pmode = 2'h0, sto, avg;
	logic lce = 1'b1, serr = 1'b0, inpkt = 1'b0, sact = 1'b0, iraw = 1'b0, wpin = 1'b0;
	logic spd, jumbo, sexp, ind, lwe, lw;
	logic [4:0] addr;
	logic [2:0] warn, fail;
	int miscompares = 0, checked = 0, cycles = 0, cnt_model = 0;
	// The line has a pull-up, so a released line reads one.
	assign mdio_w = mdio_oe_o ? mdio_o : (mgr_oe ? mgr_d : 1'b1);
	wire logic [4:0] ea = {3'b001, strap};
	wire logic [15:0] pins2 = {addr, avg, warn, fail, jumbo, sto};
	pcr_regs #(.SLEEP_TO0_CYC(4), .SLEEP_TO1_CYC(8), .SLEEP_TO2_CYC(12), .SLEEP_TO3_CYC(16))
	pcr_regs_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .mdc_i(mdc),
		.mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .addr_strap_i(strap),
		.power_mode_i(pmode), .link_ctrl_en_i(lce), .sym_err_i(serr), .rx_in_packet_i(inpkt),
		.sleep_req_active_i(sact), .indicator_raw_i(iraw), .wake_pin_i(wpin),
		.self_power_down_en_o(spd), .phy_mgmt_addr_o(addr), .quality_avg_len_o(avg),
		.quality_warn_thresh_o(warn), .quality_fail_thresh_o(fail), .jumbo_en_o(jumbo),
		.sleep_req_timeout_o(sto), .sleep_req_expired_o(sexp), .indicator_o(ind),
		.local_wake_en_o(lwe), .local_wake_o(lw));
	pcr_mgr pcr_mgr_inst (.ref_clk_i(ref_clk_i), .mdio_i(mdio_w), .mdc_o(mdc),
		.mdio_o(mgr_d), .mdio_oe_o(mgr_oe));
	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// The run needs about 75000 cycles; a hang is cut off well above that.
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Reads ignore bit 0 of the first configuration register, which is reserved.
	task automatic rdc(input string nm, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] exp);
		logic [15:0] v;
		pcr_mgr_inst.frame(PCR_OP_READ, phy, rg, 16'h0000, v);
		if (rg == PCR_ADDR_CFG_ONE) begin
			v[0] = exp[0];
		end
		chk(nm, v, exp);
	endtask
	task automatic wr(input logic [4:0] rg, input logic [15:0] d);
		logic [15:0] v;
		pcr_mgr_inst.frame(PCR_OP_WRITE, ea, rg, d, v);
	endtask
	// Outside a packet every error counts; inside one only the first does.
	task automatic pulses(input int n, input logic pkt);
		@(posedge ref_clk_i) inpkt <= pkt;
		repeat (n) begin
			@(posedge ref_clk_i) serr <= 1'b1;
			@(posedge ref_clk_i) serr <= 1'b0;
		end
		@(posedge ref_clk_i) inpkt <= 1'b0;
		cnt_model += pkt ? 1 : n;
	endtask
	initial begin
		logic [15:0] w;
		int i;
		w = 16'($urandom(32'h2144));
		strap = w[1:0];
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk("cfg2 pins", pins2, {ea, 11'h245});
		rdc("cfg2", ea, PCR_ADDR_CFG_TWO, {ea, 11'h245});
		rdc("cfg1", ea, PCR_ADDR_CFG_ONE, 16'h0000);
		$display("Reset values done");
		for (i = 0; i < 8; i++) begin
			w = 16'($urandom());
			w[10:0] = {i[1:0], i[2:0], 3'(7 - i), i[0], i[1:0]};
			wr(PCR_ADDR_CFG_TWO, w);
			chk("cfg2 pins", pins2, {ea, w[10:0]});
			rdc("cfg2", ea, PCR_ADDR_CFG_TWO, {ea, w[10:0]});
		end
		$display("Config two done");
		wr(PCR_ADDR_CFG_ONE, 16'h0003);
		chk("self pd", 16'(spd), 16'h1);
		rdc("cfg1", ea, PCR_ADDR_CFG_ONE, 16'h0002);
		for (i = 0; i < 4; i++) begin
			pmode <= 2'(i);
			wpin <= i[0];
			repeat (3) @(posedge ref_clk_i);
			chk("wake en", 16'(lwe), 16'(i != 0));
			chk("wake", 16'(lw), 16'(i[0]));
		end
		wr(PCR_ADDR_CFG_ONE, 16'h0008);
		chk("self pd", 16'(spd), 16'h0);
		chk("wake en", 16'(lwe), 16'h0);
		iraw <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		iraw <= 1'b0;
		repeat (PCR_INDICATOR_STRETCH_CYC - 10) @(posedge ref_clk_i);
		chk("indicator", 16'(ind), 16'h1);
		repeat (20) @(posedge ref_clk_i);
		chk("indicator", 16'(ind), 16'h0);
		wr(PCR_ADDR_CFG_ONE, 16'h0000);
		pmode <= 2'h0;
		$display("Config one done");
		rdc("count", ea, PCR_ADDR_SYMERR, 16'h0);
		pulses($urandom_range(9, 1), 1'b0);
		lce <= 1'b0;
		pulses(5, 1'b1);
		pulses(2, 1'b1);
		lce <= 1'b1;
		rdc("count", ea, PCR_ADDR_SYMERR, 16'(cnt_model));
		ce_i <= 1'b0;
		pulses(3, 1'b0);
		ce_i <= 1'b1;
		rdc("frozen", ea, PCR_ADDR_SYMERR, 16'h0000);
		cnt_model = 0;
		rdc("count", ea, PCR_ADDR_SYMERR, 16'(cnt_model));
		serr <= 1'b1;
		repeat (65540) @(posedge ref_clk_i);
		serr <= 1'b0;
		rdc("count", ea, PCR_ADDR_SYMERR, 16'hffff);
		rdc("count", ea, PCR_ADDR_SYMERR, 16'h0);
		$display("Counter done");
		for (i = 0; i < 4; i++) begin
			wr(PCR_ADDR_CFG_TWO, {5'h0, 9'h091, 2'(i)});
			sact <= 1'b1;
			repeat (4 * i + 2) @(posedge ref_clk_i);
			chk("expired", 16'(sexp), 16'h0);
			repeat (6) @(posedge ref_clk_i);
			chk("expired", 16'(sexp), 16'h1);
			sact <= 1'b0;
			repeat (2) @(posedge ref_clk_i);
			chk("expired", 16'(sexp), 16'h0);
		end
		$display("Sleep time-out done");
		rdc("other addr", ea ^ 5'h01, PCR_ADDR_CFG_TWO, 16'hffff);
		rdc("unmapped", ea, 5'h15, 16'hffff);
		$display("Addressing done");
		summarize();
	end
endmodule
